//--- core/stream_cfg.svh
// Purpose: Offsets, field positions, reset values and sizes of the stream control registers
// Assumes: Included by bare name from every core file
// Notes: Definitions only
`ifndef STREAM_CTRL_CFG_SVH
`define STREAM_CTRL_CFG_SVH

`define CH_COUNT 8
`define WORD_BITS 14
`define BITS_W 4

`define ADDR_PATTERN_TWO_HIGH 8'h1c
`define ADDR_STREAM_FORMAT 8'h21
`define ADDR_CHANNEL_POWER 8'h22

`define RST_PATTERN_TWO_HIGH 8'h00
`define RST_STREAM_FORMAT 8'h00
`define RST_CHANNEL_POWER 8'h00

`define FMT_LSB_FIRST_BIT 7
`define FMT_LOW_RATE_BIT 3
`define FMT_RES_HI 2
`define FMT_RES_LO 0
`define CHP_OUT_RST_BIT 1
`define CHP_PDOWN_BIT 0

`define RES_8 3'h1
`define RES_10 3'h2
`define RES_12 3'h3
`define RES_14 3'h4

`define BITS_8 4'h8
`define BITS_10 4'ha
`define BITS_12 4'hc
`define BITS_14 4'he

`define SLOW_DIV 1'h1

`endif

//--- core/stream_pkg.sv
// Purpose: Types shared by the stream control block
// Assumes: stream_cfg.svh constants
// Notes: Channel count fixed by CH_COUNT
`include "stream_cfg.svh"

package stream_pkg;

	typedef struct packed {
		logic [7:0] pattern_two_high;
		logic lsb_first;
		logic low_rate;
		logic [2:0] resolution;
		logic [`CH_COUNT-1:0] out_rst;
		logic [`CH_COUNT-1:0] pdown;
		logic [7:0] rdata;
		logic rvalid;
	} regs_state_t;

	typedef struct packed {
		logic [`WORD_BITS-1:0] shift;
		logic [`BITS_W-1:0] count;
		logic [`BITS_W-1:0] nbits;
		logic lsb_first;
		logic slow;
		logic div;
		logic busy;
		logic data;
		logic frame;
	} shift_state_t;

endpackage

//--- core/word_shifter.sv
// Purpose: Serialises one channel's output word
// Assumes: Word, load and controls come from logic on the same clock
// Notes: Word is truncated to its top nbits bits
`include "stream_cfg.svh"
`timescale 1ns/10ps

module word_shifter #(
	parameter int WIDTH = `WORD_BITS
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic out_rst_i,
	input wire logic pdown_i,
	input wire logic lsb_first_i,
	input wire logic slow_i,
	input wire logic [`BITS_W-1:0] nbits_i,
	input wire logic load_i,
	input wire logic [WIDTH-1:0] word_i,
	output logic data_o,
	output logic frame_o,
	output logic busy_o
);

	stream_pkg::shift_state_t state_reg;
	stream_pkg::shift_state_t state_next;

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic [`BITS_W-1:0] idx;
		idx = '0;
		state_next = state_reg;
		state_next.frame = 1'b0;
		if (out_rst_i || pdown_i) begin
			state_next = '0;
		end else if (!state_reg.busy) begin
			if (load_i) begin
				state_next.shift = word_i >> (WIDTH - int'(nbits_i));
				state_next.nbits = nbits_i;
				state_next.count = nbits_i;
				state_next.lsb_first = lsb_first_i;
				state_next.slow = slow_i;
				state_next.div = 1'b0;
				state_next.busy = 1'b1;
			end
		end else if (state_reg.slow && state_reg.div != `SLOW_DIV) begin
			state_next.div = state_reg.div + 1'b1;
		end else begin
			state_next.div = 1'b0;
			if (state_reg.lsb_first) begin
				idx = state_reg.nbits - state_reg.count;
			end else begin
				idx = state_reg.count - 1'b1;
			end
			state_next.data = state_reg.shift[idx];
			state_next.frame = (state_reg.count == state_reg.nbits);
			state_next.count = state_reg.count - 1'b1;
			state_next.busy = (state_reg.count != 1'b1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign data_o = state_reg.data;
	assign frame_o = state_reg.frame;
	assign busy_o = state_reg.busy;

endmodule

//--- core/stream_ctrl_regs.sv
// Purpose: Serial output stream control registers with per-channel word serialisers
// Assumes: Register port and samples come from the control port logic on ref_clk_i
// Notes: Reads return data one cycle after the read strobe
// Function
// - Register 0x1c holds bits 15 to 8 of the second custom test pattern and resets to 0.
// - Words go out MSB first by default and LSB first when the bit-order bit is set.
// - A low encode rate bit, cleared at reset, slows the output timing for slow samples.
// - Resolution codes 001, 010, 011, 100 give 8, 10, 12, 14 bit words.
// - The per-channel output reset bit holds that channel's output logic in reset.
// - The per-channel power-down bit powers down that channel; clear keeps it running.
// - Stream format applies to all channels; channel power applies to selected ones only.
`include "stream_cfg.svh"
`timescale 1ns/10ps

module stream_ctrl_regs #(
	parameter int CHANNELS = `CH_COUNT,
	parameter int WIDTH = `WORD_BITS
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [CHANNELS-1:0] chan_sel_i,
	input wire logic [CHANNELS*WIDTH-1:0] sample_i,
	input wire logic sample_load_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic [7:0] custom_pattern_two_high_o,
	output logic lsb_first_o,
	output logic low_rate_o,
	output logic [2:0] resolution_o,
	output logic [`BITS_W-1:0] word_bits_o,
	output logic [CHANNELS-1:0] chan_pdown_o,
	output logic [CHANNELS-1:0] chan_out_rst_o,
	output logic [CHANNELS-1:0] ser_data_o,
	output logic [CHANNELS-1:0] ser_frame_o,
	output logic [CHANNELS-1:0] ser_busy_o
);

	stream_pkg::regs_state_t state_reg;
	stream_pkg::regs_state_t state_next;

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [`BITS_W-1:0] res_bits(input logic [2:0] code);
		logic [`BITS_W-1:0] bits;
		unique case (code)
			`RES_8: bits = `BITS_8;
			`RES_10: bits = `BITS_10;
			`RES_12: bits = `BITS_12;
			`RES_14: bits = `BITS_14;
			default: bits = `BITS_14;
		endcase
		return bits;
	endfunction

	function automatic int first_sel(input logic [CHANNELS-1:0] sel);
		int idx;
		idx = 0;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (sel[i]) begin
				idx = i;
			end
		end
		return idx;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register writes and reads
	always_comb begin
		int ch;
		logic [7:0] fmt;
		logic [7:0] chp;
		ch = first_sel(chan_sel_i);
		fmt = '0;
		chp = '0;
		state_next = state_reg;
		state_next.rvalid = reg_rd_i;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				`ADDR_PATTERN_TWO_HIGH: begin
					state_next.pattern_two_high = reg_wdata_i;
				end
				`ADDR_STREAM_FORMAT: begin
					state_next.lsb_first = reg_wdata_i[`FMT_LSB_FIRST_BIT];
					state_next.low_rate = reg_wdata_i[`FMT_LOW_RATE_BIT];
					state_next.resolution = reg_wdata_i[`FMT_RES_HI:`FMT_RES_LO];
				end
				`ADDR_CHANNEL_POWER: begin
					for (int i = 0; i < CHANNELS; i++) begin
						if (chan_sel_i[i]) begin
							state_next.out_rst[i] = reg_wdata_i[`CHP_OUT_RST_BIT];
							state_next.pdown[i] = reg_wdata_i[`CHP_PDOWN_BIT];
						end
					end
				end
				default: begin
				end
			endcase
		end
		fmt[`FMT_LSB_FIRST_BIT] = state_reg.lsb_first;
		fmt[`FMT_LOW_RATE_BIT] = state_reg.low_rate;
		fmt[`FMT_RES_HI:`FMT_RES_LO] = state_reg.resolution;
		chp[`CHP_OUT_RST_BIT] = state_reg.out_rst[ch];
		chp[`CHP_PDOWN_BIT] = state_reg.pdown[ch];
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				`ADDR_PATTERN_TWO_HIGH: state_next.rdata = state_reg.pattern_two_high;
				`ADDR_STREAM_FORMAT: state_next.rdata = fmt;
				`ADDR_CHANNEL_POWER: state_next.rdata = chp;
				default: state_next.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg.pattern_two_high <= `RST_PATTERN_TWO_HIGH;
			state_reg.lsb_first <= 1'(`RST_STREAM_FORMAT >> `FMT_LSB_FIRST_BIT);
			state_reg.low_rate <= 1'(`RST_STREAM_FORMAT >> `FMT_LOW_RATE_BIT);
			state_reg.resolution <= 3'(`RST_STREAM_FORMAT >> `FMT_RES_LO);
			state_reg.out_rst <= {CHANNELS{1'(`RST_CHANNEL_POWER >> `CHP_OUT_RST_BIT)}};
			state_reg.pdown <= {CHANNELS{1'(`RST_CHANNEL_POWER >> `CHP_PDOWN_BIT)}};
			state_reg.rdata <= '0;
			state_reg.rvalid <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata_o = state_reg.rdata;
	assign reg_rvalid_o = state_reg.rvalid;
	assign custom_pattern_two_high_o = state_reg.pattern_two_high;
	assign lsb_first_o = state_reg.lsb_first;
	assign low_rate_o = state_reg.low_rate;
	assign resolution_o = state_reg.resolution;
	assign word_bits_o = res_bits(state_reg.resolution);
	assign chan_pdown_o = state_reg.pdown;
	assign chan_out_rst_o = state_reg.out_rst;

	////////////////////////////////////////////////////////////////////////////////
	// Per-channel serialisers
	for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
		word_shifter #(
			.WIDTH(WIDTH)
		) u_shift (
			.ref_clk_i(ref_clk_i),
			.sys_rst_i(sys_rst_i),
			.out_rst_i(state_reg.out_rst[g]),
			.pdown_i(state_reg.pdown[g]),
			.lsb_first_i(state_reg.lsb_first),
			.slow_i(state_reg.low_rate),
			.nbits_i(res_bits(state_reg.resolution)),
			.load_i(sample_load_i),
			.word_i(sample_i[g*WIDTH +: WIDTH]),
			.data_o(ser_data_o[g]),
			.frame_o(ser_frame_o[g]),
			.busy_o(ser_busy_o[g])
		);
	end

endmodule

//--- testbench/stream_ctrl_regs_monitor.sv
// Purpose: Port assertions for the stream control block
// Assumes: Bound to stream_ctrl_regs
// Notes: Serial timing watched on channel 0
`include "stream_cfg.svh"
`timescale 1ns/10ps
module stream_ctrl_regs_monitor #(
	parameter int CHANNELS = 8,
	parameter int WIDTH = 14
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic [CHANNELS-1:0] chan_sel_i,
	input wire logic sample_load_i,
	input wire logic [7:0] custom_pattern_two_high_o,
	input wire logic lsb_first_o,
	input wire logic low_rate_o,
	input wire logic [2:0] resolution_o,
	input wire logic [3:0] word_bits_o,
	input wire logic [CHANNELS-1:0] chan_pdown_o,
	input wire logic [CHANNELS-1:0] chan_out_rst_o,
	input wire logic [CHANNELS-1:0] ser_frame_o,
	input wire logic [CHANNELS-1:0] ser_busy_o
);
default clocking cb @(posedge ref_clk_i); endclocking
default disable iff (sys_rst_i);
////////////////////////////////////////////////////////////////////////
sequence s_load(lr);
	sample_load_i && !ser_busy_o[0] && !chan_pdown_o[0] && !chan_out_rst_o[0]
		&& low_rate_o == lr && !reg_wr_i;
endsequence
a_pattern_write: assert property (reg_wr_i && reg_addr_i == 8'h1c |=>
	custom_pattern_two_high_o == $past(reg_wdata_i)) else $error("pattern write lost");
a_order_write: assert property (reg_wr_i && reg_addr_i == 8'h21 |=>
	lsb_first_o == $past(reg_wdata_i[7]) && resolution_o == $past(reg_wdata_i[2:0]))
	else $error("format write lost");
a_low_rate: assert property (reg_wr_i && reg_addr_i == 8'h21 |=>
	low_rate_o == $past(reg_wdata_i[3])) else $error("low rate write lost");
a_res_decode: assert property (word_bits_o == (resolution_o == 3'h1 ? 4'h8 :
	resolution_o == 3'h2 ? 4'ha : resolution_o == 3'h3 ? 4'hc : 4'he)) else $error("bad length");
a_rst_quiet: assert property ((chan_out_rst_o & $past(chan_out_rst_o)
	& (ser_busy_o | ser_frame_o)) == 0) else $error("channel active in reset");
a_pdown_quiet: assert property ((chan_pdown_o & $past(chan_pdown_o)
	& (ser_busy_o | ser_frame_o)) == 0) else $error("channel active in power-down");
a_local_write: assert property (reg_wr_i && reg_addr_i == 8'h22 |=>
	((chan_pdown_o ^ $past(chan_pdown_o)) & ~$past(chan_sel_i)) == 0) else $error("wrong channel");
a_first_bit: assert property (s_load(1'b0) |-> ##2 ser_frame_o[0]) else $error("late word");
a_slow_first: assert property (s_load(1'b1) |-> ##3 ser_frame_o[0]) else $error("slow word");
endmodule
bind stream_ctrl_regs stream_ctrl_regs_monitor #(.CHANNELS(CHANNELS), .WIDTH(WIDTH)) mon_u (
	.ref_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .chan_sel_i, .sample_load_i,
	.custom_pattern_two_high_o, .lsb_first_o, .low_rate_o, .resolution_o, .word_bits_o,
	.chan_pdown_o, .chan_out_rst_o, .ser_frame_o, .ser_busy_o);

//--- testbench/test_stream_ctrl_regs.sv
// Purpose: Self-checking bench for the stream control block
// Assumes: Inputs change at falling edges
// Notes: Register model kept in bench variables
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_stream_ctrl_regs;
logic ref_clk_i = 1'h0, sys_rst_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0, sample_load_i = 1'h0;
logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, chan_sel_i = 8'h00;
logic [111:0] sample_i = 112'h0;
logic [7:0] reg_rdata_o, custom_pattern_two_high_o, chan_pdown_o, chan_out_rst_o;
logic [7:0] ser_data_o, ser_frame_o, ser_busy_o;
logic reg_rvalid_o, lsb_first_o, low_rate_o;
logic [2:0] resolution_o;
logic [3:0] word_bits_o;
logic [7:0] m_pat = 8'h00, m_fmt = 8'h00, m_pd = 8'h00, m_or = 8'h00;
int n_mismatch = 0, checks = 0, i, j;
stream_ctrl_regs dut_u (.ref_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
	.chan_sel_i, .sample_i, .sample_load_i, .reg_rdata_o, .reg_rvalid_o, .custom_pattern_two_high_o,
	.lsb_first_o, .low_rate_o, .resolution_o, .word_bits_o, .chan_pdown_o, .chan_out_rst_o,
	.ser_data_o, .ser_frame_o, .ser_busy_o);
initial forever #50 ref_clk_i = ~ref_clk_i;
////////////////////////////////////////////////////////////////////////
task print_verdict;
	if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
	else $display("DONE - FAIL");
	$finish;
endtask
task wr(input logic [7:0] a, input logic [7:0] d);
	@(negedge ref_clk_i);
	reg_addr_i = a;
	reg_wdata_i = d;
	reg_wr_i = 1'h1;
	@(negedge ref_clk_i);
	reg_wr_i = 1'h0;
	if (a == 8'h1c) m_pat = d;
	if (a == 8'h21) m_fmt = d & 8'h8f;
	if (a == 8'h22) begin
		m_pd = (m_pd & ~chan_sel_i) | ({8{d[0]}} & chan_sel_i);
		m_or = (m_or & ~chan_sel_i) | ({8{d[1]}} & chan_sel_i);
	end
endtask
task rd(input logic [7:0] a, input logic [7:0] e);
	@(negedge ref_clk_i);
	reg_addr_i = a;
	reg_rd_i = 1'h1;
	@(negedge ref_clk_i);
	reg_rd_i = 1'h0;
	`CHK("rvalid", 1'h1, reg_rvalid_o)
	`CHK("rdata", e, reg_rdata_o)
endtask
task word(input int c);
	int n, k, e, got;
	logic [13:0] s;
	n = m_fmt[2:0] == 3'h1 ? 8 : m_fmt[2:0] == 3'h2 ? 10 : m_fmt[2:0] == 3'h3 ? 12 : 14;
	`CHK("bits", 4'(n), word_bits_o)
	@(negedge ref_clk_i);
	sample_i = 112'({$urandom, $urandom, $urandom, $urandom});
	sample_load_i = 1'h1;
	@(negedge ref_clk_i);
	sample_load_i = 1'h0;
	s = sample_i[c*14 +: 14];
	e = 0;
	for (k = 0; k < n; k++) e = (e << 1) | (m_fmt[7] ? s[14-n+k] : s[13-k]);
	k = 0;
	while (ser_frame_o[c] !== 1'h1 && k < 9) begin
		@(negedge ref_clk_i);
		k++;
	end
	`CHK("latency", m_fmt[3] ? 2 : 1, k)
	got = 0;
	for (k = 0; k < n; k++) begin
		got = (got << 1) | ser_data_o[c];
		repeat (m_fmt[3] ? 2 : 1) @(negedge ref_clk_i);
	end
	`CHK("word", e, got)
	repeat (3) @(negedge ref_clk_i);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	#(100 * 20000);
	n_mismatch++;
	print_verdict;
end
initial begin
	void'($urandom(5));
	repeat (4) @(negedge ref_clk_i);
	sys_rst_i = 1'h0;
	chan_sel_i = 8'h01;
	rd(8'h1c, 8'h00);
	rd(8'h21, 8'h00);
	rd(8'h22, 8'h00);
	rd(8'h30, 8'h00);
	wr(8'h1c, 8'($urandom));
	rd(8'h1c, m_pat);
	`CHK("pattern", m_pat, custom_pattern_two_high_o)
	for (i = 0; i < 10; i++) begin
		wr(8'h21, {i[0], 3'h0, i == 9, 3'(i >> 1)});
		rd(8'h21, m_fmt);
		`CHK("format", m_fmt, {lsb_first_o, 3'h0, low_rate_o, resolution_o})
		word($urandom % 8);
	end
	for (i = 0; i < 4; i++) begin
		chan_sel_i = 8'($urandom);
		wr(8'h22, 8'(i));
		`CHK("pdown", m_pd, chan_pdown_o)
		`CHK("outrst", m_or, chan_out_rst_o)
		j = $urandom % 8;
		chan_sel_i = 8'h01 << j;
		rd(8'h22, {6'h00, m_or[j], m_pd[j]});
		@(negedge ref_clk_i);
		sample_load_i = 1'h1;
		@(negedge ref_clk_i);
		sample_load_i = 1'h0;
		`CHK("busy", ~(m_pd | m_or), ser_busy_o)
		repeat (40) @(negedge ref_clk_i);
	end
	print_verdict;
end
endmodule
